// ===== core/bsi_consts.svh
// constants for the barrier state indicator: offsets, fields, reset values, angle limits
// Notes on behaviour
// - The traffic-light indication goes to exactly one of the physical outputs or to none.
// - A routing setting of off stops that indication from driving any physical output.
// - The traffic light is inactive while the angle is from 0 up to below the trigger level.
// - The traffic light is active from the trigger level up to and including 90 degrees.
// - With a trigger level of zero the traffic light goes active as soon as raising starts.
// - Angles are degrees above horizontal, growing as the boom raises.
// - The status indication has an enable of its own, apart from routing and state map.
// - The status indication goes to one of the same physical outputs or to none.
// - Each of the seven states has its own on/off bit driving the status output.
// - In raising with an angle chosen, status starts inactive and goes active at that angle.
// - In lowering with an angle chosen, status starts active and goes inactive at that angle.
// - The raising and lowering angle choices are only 5, 10, 15, 20, 80 and 85 degrees.
// - In raising set plain on, status goes active on entering raising.
// - In lowering set plain on, status goes active on entering lowering.
`ifndef BSI_CONSTS_SVH
`define BSI_CONSTS_SVH

// register byte addresses
`define BSI_ADDR_TL_CFG     8'h00
`define BSI_ADDR_BS_CFG     8'h04
`define BSI_ADDR_BS_MAP     8'h08
`define BSI_ADDR_STATUS     8'h0C

// field positions
`define BSI_TL_ROUTE_LSB    0
`define BSI_TL_TRIG_LSB     8
`define BSI_BS_EN_BIT       0
`define BSI_BS_ROUTE_LSB    4
`define BSI_MAP_ON_LSB      0
`define BSI_MAP_RS_LSB      8
`define BSI_MAP_LW_LSB      12
`define BSI_ST_TL_BIT       0
`define BSI_ST_BS_BIT       1
`define BSI_ST_OUT_LSB      2
`define BSI_ST_STATE_LSB    8
`define BSI_ST_ANGLE_LSB    16

// reset values
`define BSI_RST_ROUTE       3'h0
`define BSI_RST_TRIG        7'h00
`define BSI_RST_MAP         7'h00
`define BSI_RST_OPT         3'h0
`define BSI_RST_DATA        32'h0000_0000

// angle limits in degrees
`define BSI_ANGLE_MAX       8'h5A
`define BSI_TRIG_MAX        7'h5A

`endif

// ===== core/bsi_indicator.sv
// traffic light and barrier status indicator with register port
`timescale 1ns/1ps
`include "bsi_consts.svh"
module bsi_indicator
  import bsi_pkg::*;
(
  input  wire logic        ref_clk,       // system clock, 20 MHz
  input  wire logic        rst,           // async reset, active high
  input  wire logic        ce,            // clock enable, freezes all state when low
  input  wire logic [2:0]  bar_state,     // barrier operating state code
  input  wire logic [7:0]  bar_angle,     // boom angle in degrees
  input  wire logic [7:0]  addr,          // register byte address
  input  wire logic [31:0] wdata,         // register write data
  input  wire logic        wr,            // write strobe
  input  wire logic        rd,            // read strobe
  output logic      [31:0] rdata,         // read data, cycle after rd
  output logic             route_relay,   // relay output, high is active
  output logic             route_aux_io,  // aux io output, high is active
  output logic             route_aux_out, // aux out output, high is active
  output logic             route_led,     // status led output, high is active
  output logic             route_sounder  // buzzer output, high is active
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // angle option code to degrees; 0 means plain on
  function automatic logic [7:0] opt_deg(input logic [2:0] code);
    case (code)
      3'h1:    opt_deg = 8'h05;
      3'h2:    opt_deg = 8'h0A;
      3'h3:    opt_deg = 8'h0F;
      3'h4:    opt_deg = 8'h14;
      3'h5:    opt_deg = 8'h50;
      3'h6:    opt_deg = 8'h55;
      default: opt_deg = 8'h00;
    endcase
  endfunction : opt_deg

  // only the listed angles are kept; anything else becomes plain on
  function automatic logic [2:0] opt_clip(input logic [2:0] code);
    opt_clip = (code == 3'h7) ? 3'h0 : code;
  endfunction : opt_clip

  // spare state codes count as unknown
  function automatic bsi_bstate_type st_clip(input logic [2:0] code);
    st_clip = (code == 3'h7) ? BSI_ST_UNKNOWN : bsi_bstate_type'(code);
  endfunction : st_clip

  ////////////////////////////////////////////////////////////////////////////
  // state

  bsi_state_type  s_r;
  bsi_state_type  s_nxt;
  bsi_bstate_type st;
  logic           entering;
  logic           ang_cond;
  logic           latch_c;
  logic [7:0]     trig_deg;
  logic [7:0]     rs_deg;
  logic [7:0]     lw_deg;
  logic           tl_c;
  logic           bs_c;
  logic [4:0]     tl_hit;
  logic [4:0]     bs_hit;

  assign st       = st_clip(bar_state);
  assign entering = (st != s_r.prev_st);
  assign trig_deg = {1'b0, s_r.tl_trig};
  assign rs_deg   = opt_deg(s_r.rs_opt);
  assign lw_deg   = opt_deg(s_r.lw_opt);

  ////////////////////////////////////////////////////////////////////////////
  // traffic light evaluation

  // angle grows upward from horizontal, so larger means more raised
  always_comb begin
    if (bar_angle > `BSI_ANGLE_MAX) begin
      tl_c = 1'b0;
    end else if (s_r.tl_trig == 7'h00) begin
      // zero level: green from the start of raising, not while parked down
      tl_c = (st == BSI_ST_RAISING) || (bar_angle != 8'h00);
    end else if (bar_angle < trig_deg) begin
      tl_c = 1'b0;
    end else begin
      tl_c = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // barrier status evaluation

  // the angle condition is latched for the rest of the move so that boom
  // jitter around the threshold cannot make the output chatter
  always_comb begin
    ang_cond = 1'b0;
    if (st == BSI_ST_RAISING) begin
      ang_cond = (bar_angle >= rs_deg);
    end else if (st == BSI_ST_LOWERING) begin
      ang_cond = (bar_angle <= lw_deg);
    end
  end

  assign latch_c = (entering ? 1'b0 : s_r.latch) | ang_cond;

  always_comb begin
    bs_c = 1'b0;
    if (s_r.bs_en && s_r.bs_map[st]) begin
      case (st)
        BSI_ST_RAISING: begin
          if (s_r.rs_opt == 3'h0) begin
            bs_c = 1'b1;
          end else begin
            bs_c = latch_c;
          end
        end
        BSI_ST_LOWERING: begin
          if (s_r.lw_opt == 3'h0) begin
            bs_c = 1'b1;
          end else begin
            bs_c = ~latch_c;
          end
        end
        default: bs_c = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output routing

  bsi_route u_tl_route (
    .lvl   (tl_c),
    .route (s_r.tl_route),
    .hit   (tl_hit)
  );

  bsi_route u_bs_route (
    .lvl   (bs_c),
    .route (s_r.bs_route),
    .hit   (bs_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state and register port

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      s_nxt.prev_st = st;
      s_nxt.latch   = latch_c;
      s_nxt.tl_lvl  = tl_c;
      s_nxt.bs_lvl  = bs_c;
      // both indications may share one output; they are or-ed there
      s_nxt.outs    = tl_hit | bs_hit;
      s_nxt.rdata   = `BSI_RST_DATA;
      if (wr) begin
        case (addr)
          `BSI_ADDR_TL_CFG: begin
            s_nxt.tl_route = wdata[`BSI_TL_ROUTE_LSB +: 3];
            if (wdata[`BSI_TL_TRIG_LSB +: 7] > `BSI_TRIG_MAX) begin
              s_nxt.tl_trig = `BSI_TRIG_MAX;
            end else begin
              s_nxt.tl_trig = wdata[`BSI_TL_TRIG_LSB +: 7];
            end
          end
          `BSI_ADDR_BS_CFG: begin
            s_nxt.bs_en    = wdata[`BSI_BS_EN_BIT];
            s_nxt.bs_route = wdata[`BSI_BS_ROUTE_LSB +: 3];
          end
          `BSI_ADDR_BS_MAP: begin
            s_nxt.bs_map = wdata[`BSI_MAP_ON_LSB +: 7];
            s_nxt.rs_opt = opt_clip(wdata[`BSI_MAP_RS_LSB +: 3]);
            s_nxt.lw_opt = opt_clip(wdata[`BSI_MAP_LW_LSB +: 3]);
          end
          default: ;
        endcase
      end
      if (rd) begin
        case (addr)
          `BSI_ADDR_TL_CFG: begin
            s_nxt.rdata[`BSI_TL_ROUTE_LSB +: 3] = s_r.tl_route;
            s_nxt.rdata[`BSI_TL_TRIG_LSB +: 7]  = s_r.tl_trig;
          end
          `BSI_ADDR_BS_CFG: begin
            s_nxt.rdata[`BSI_BS_EN_BIT]         = s_r.bs_en;
            s_nxt.rdata[`BSI_BS_ROUTE_LSB +: 3] = s_r.bs_route;
          end
          `BSI_ADDR_BS_MAP: begin
            s_nxt.rdata[`BSI_MAP_ON_LSB +: 7] = s_r.bs_map;
            s_nxt.rdata[`BSI_MAP_RS_LSB +: 3] = s_r.rs_opt;
            s_nxt.rdata[`BSI_MAP_LW_LSB +: 3] = s_r.lw_opt;
          end
          `BSI_ADDR_STATUS: begin
            s_nxt.rdata[`BSI_ST_TL_BIT]          = s_r.tl_lvl;
            s_nxt.rdata[`BSI_ST_BS_BIT]          = s_r.bs_lvl;
            s_nxt.rdata[`BSI_ST_OUT_LSB +: 5]    = s_r.outs;
            s_nxt.rdata[`BSI_ST_STATE_LSB +: 3]  = s_r.prev_st;
            s_nxt.rdata[`BSI_ST_ANGLE_LSB +: 8]  = bar_angle;
          end
          default: s_nxt.rdata = `BSI_RST_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r.tl_route <= `BSI_RST_ROUTE;
      s_r.tl_trig  <= `BSI_RST_TRIG;
      s_r.bs_en    <= 1'b0;
      s_r.bs_route <= `BSI_RST_ROUTE;
      s_r.bs_map   <= `BSI_RST_MAP;
      s_r.rs_opt   <= `BSI_RST_OPT;
      s_r.lw_opt   <= `BSI_RST_OPT;
      s_r.prev_st  <= BSI_ST_UNKNOWN;
      s_r.latch    <= 1'b0;
      s_r.tl_lvl   <= 1'b0;
      s_r.bs_lvl   <= 1'b0;
      s_r.outs     <= 5'h00;
      s_r.rdata    <= `BSI_RST_DATA;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata         = s_r.rdata;
  assign route_relay   = s_r.outs[0];
  assign route_aux_io  = s_r.outs[1];
  assign route_aux_out = s_r.outs[2];
  assign route_led     = s_r.outs[3];
  assign route_sounder = s_r.outs[4];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_enter_raise;
    ce && st == BSI_ST_RAISING && s_r.prev_st != BSI_ST_RAISING;
  endsequence

  sequence seq_enter_lower;
    ce && st == BSI_ST_LOWERING && s_r.prev_st != BSI_ST_LOWERING;
  endsequence

  sequence seq_bs_armed(bsi_bstate_type cs);
    s_r.bs_en && s_r.bs_map[cs];
  endsequence

  AST_TL_ONE_OUTPUT: assert property ($onehot0(tl_hit))
    else $error("traffic light drives more than one output");

  AST_OFF_SILENT: assert property (
    ce && s_r.tl_route == BSI_RT_OFF && s_r.bs_route == BSI_RT_OFF |=> s_r.outs == 5'h00)
    else $error("output driven while both routes are off");

  AST_TL_BELOW: assert property (
    ce && s_r.tl_trig != 7'h00 && bar_angle < trig_deg |=> !s_r.tl_lvl)
    else $error("traffic light active below trigger level");

  AST_TL_ABOVE: assert property (
    ce && s_r.tl_trig != 7'h00 && bar_angle >= trig_deg && bar_angle <= `BSI_ANGLE_MAX
    |=> s_r.tl_lvl)
    else $error("traffic light inactive at or above trigger level");

  AST_TL_ZERO: assert property (
    seq_enter_raise ##0 s_r.tl_trig == 7'h00 && bar_angle <= `BSI_ANGLE_MAX |=> s_r.tl_lvl)
    else $error("zero trigger level not active on raising");

  AST_BS_DISABLED: assert property (
    ce && !s_r.bs_en |=> !s_r.bs_lvl)
    else $error("status active while disabled");

  AST_BS_ROUTE: assert property (
    ce && s_r.bs_route == BSI_RT_RELAY && s_r.tl_route == BSI_RT_OFF
    |=> route_relay == s_r.bs_lvl)
    else $error("status not routed to relay");

  AST_BS_MAP: assert property (
    ce && st != BSI_ST_RAISING && st != BSI_ST_LOWERING
    |=> s_r.bs_lvl == ($past(s_r.bs_en) && $past(s_r.bs_map[st])))
    else $error("status does not follow state map");

  AST_RAISE_START: assert property (
    seq_enter_raise ##0 seq_bs_armed(BSI_ST_RAISING) ##0 s_r.rs_opt != 3'h0
    ##0 bar_angle < rs_deg |=> !s_r.bs_lvl)
    else $error("raising status not inactive at start");

  AST_LOWER_START: assert property (
    seq_enter_lower ##0 seq_bs_armed(BSI_ST_LOWERING) ##0 s_r.lw_opt != 3'h0
    ##0 bar_angle > lw_deg |=> s_r.bs_lvl)
    else $error("lowering status not active at start");

  AST_OPT_LEGAL: assert property (s_r.rs_opt != 3'h7 && s_r.lw_opt != 3'h7)
    else $error("illegal angle option stored");

  AST_RAISE_PLAIN: assert property (
    seq_enter_raise ##0 seq_bs_armed(BSI_ST_RAISING) ##0 s_r.rs_opt == 3'h0
    |=> s_r.bs_lvl)
    else $error("plain raising status not active");

  AST_LOWER_PLAIN: assert property (
    seq_enter_lower ##0 seq_bs_armed(BSI_ST_LOWERING) ##0 s_r.lw_opt == 3'h0
    |=> s_r.bs_lvl)
    else $error("plain lowering status not active");

  AST_FROZEN: assert property (!ce |=> $stable(s_r.outs) && $stable(rdata))
    else $error("state moved while clock enable low");

endmodule : bsi_indicator

// ===== core/bsi_pkg.sv
// types for the barrier state indicator
package bsi_pkg;

  // physical output routing codes; 6 and 7 behave as off
  typedef enum logic [2:0] {
    BSI_RT_OFF    = 3'b000,
    BSI_RT_RELAY  = 3'b001,
    BSI_RT_AUX_IO = 3'b010,
    BSI_RT_AUXOUT = 3'b011,
    BSI_RT_LED    = 3'b100,
    BSI_RT_SOUND  = 3'b101
  } bsi_route_type;

  // barrier operating states
  typedef enum logic [2:0] {
    BSI_ST_LOWERED  = 3'b000,
    BSI_ST_PART_LWD = 3'b001,
    BSI_ST_LOWERING = 3'b010,
    BSI_ST_RAISED   = 3'b011,
    BSI_ST_PART_RSD = 3'b100,
    BSI_ST_RAISING  = 3'b101,
    BSI_ST_UNKNOWN  = 3'b110
  } bsi_bstate_type;

  typedef struct packed {
    logic [2:0]     tl_route;
    logic [6:0]     tl_trig;
    logic           bs_en;
    logic [2:0]     bs_route;
    logic [6:0]     bs_map;
    logic [2:0]     rs_opt;
    logic [2:0]     lw_opt;
    bsi_bstate_type prev_st;
    logic           latch;
    logic           tl_lvl;
    logic           bs_lvl;
    logic [4:0]     outs;
    logic [31:0]    rdata;
  } bsi_state_type;

endpackage : bsi_pkg

// ===== core/bsi_route.sv
// maps one indication level onto the selected physical output
`timescale 1ns/1ps
module bsi_route
  import bsi_pkg::*;
(
  input  wire logic       lvl,    // indication level, high is active
  input  wire logic [2:0] route,  // routing code
  output logic      [4:0] hit     // one bit per physical output
);

  always_comb begin
    hit = 5'h00;
    case (route)
      BSI_RT_RELAY:  hit[0] = lvl;
      BSI_RT_AUX_IO: hit[1] = lvl;
      BSI_RT_AUXOUT: hit[2] = lvl;
      BSI_RT_LED:    hit[3] = lvl;
      BSI_RT_SOUND:  hit[4] = lvl;
      // spare codes fall to off rather than to a random output
      default:       hit = 5'h00;
    endcase
  end

endmodule : bsi_route

// ===== sim/bsi_far_end.sv
// far-side model: external traffic light or access equipment watching the five outputs
`timescale 1ns/1ps
module bsi_far_end (
  input  wire logic       ref_clk, // system clock
  input  wire logic       rst,     // async reset, active high
  input  wire logic [4:0] drive,   // relay, aux io, aux out, led, sounder
  output logic      [4:0] seen     // sticky: each output was ever active
);
  //////////////////////////////////////////////////////////////////////////////
  // the equipment only latches contact closures; it never drives back
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen <= 5'h00;
    end else begin
      seen <= seen | drive;
    end
  end
endmodule : bsi_far_end

// ===== sim/bsi_indicator_tb_top.sv
// self-checking testbench for the barrier state indicator
`timescale 1ns/1ps
module bsi_indicator_tb_top;
  import bsi_pkg::*;
  logic        ref_clk, rst, ce, wr, rd;
  logic [2:0]  bar_state;
  logic [7:0]  bar_angle, addr;
  logic [31:0] wdata, rdata, d;
  logic        relay, aux_io, aux_out, led, sounder;
  logic [4:0]  seen, outs;
  logic [2:0]  tl_route, bs_route, rs, lw;
  logic [6:0]  trig, bs_map;
  logic        bs_en;
  int          miscompares = 0, checked = 0, cyc = 0;
  logic [7:0]  deg [7] = '{8'd0, 8'd5, 8'd10, 8'd15, 8'd20, 8'd80, 8'd85};
  assign outs = {relay, aux_io, aux_out, led, sounder};
  bsi_indicator uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .bar_state(bar_state),
    .bar_angle(bar_angle), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .route_relay(relay), .route_aux_io(aux_io), .route_aux_out(aux_out),
    .route_led(led), .route_sounder(sounder));
  bsi_far_end far (.ref_clk(ref_clk), .rst(rst), .drive(outs), .seen(seen));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("errors: miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : chk
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    rd <= 1'b1; addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic cfg;
    wr_reg(8'h00, {17'h0_0000, trig, 5'h00, tl_route});
    wr_reg(8'h04, {25'h000_0000, bs_route, 3'h0, bs_en});
    wr_reg(8'h08, {17'h0_0000, lw, 1'b0, rs, 1'b0, bs_map});
    if (trig > 7'h5A) trig = 7'h5A; // writes above 90 clamp
  endtask : cfg
  function automatic logic [4:0] rv(input logic [2:0] c, input logic l);
    return (l && c >= 3'h1 && c <= 3'h5) ? (5'h10 >> (c - 3'h1)) : 5'h00;
  endfunction : rv
  // static expectation, valid where no angle option is active
  function automatic logic [4:0] exp_vec(input logic [2:0] st, input logic [7:0] ang);
    logic [2:0] s;
    logic       t;
    s = (st == 3'h7) ? 3'h6 : st;
    t = (ang <= 8'h5A) && ((trig == 7'h00) ? (s == 3'h5 || ang != 8'h00) : ang >= {1'b0, trig});
    return rv(tl_route, t) | rv(bs_route, bs_en && bs_map[s]);
  endfunction : exp_vec
  task automatic drv(input logic [2:0] st, input logic [7:0] ang);
    @(posedge ref_clk);
    bar_state <= st; bar_angle <= ang;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : drv
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
    bar_state = 3'h0; bar_angle = 8'h00;
    void'($urandom(32'hd169));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk(outs, 5'h00);
    // routing table, status route is 7 minus light route, so the two never share an output
    for (int r = 0; r < 8; r++) begin
      tl_route = 3'(r); bs_route = 3'(7 - r); bs_en = 1'b1; trig = 7'd30; bs_map = 7'h08;
      rs = 3'h0; lw = 3'h0;
      cfg();
      drv(3'h3, 8'd45); chk(outs, exp_vec(3'h3, 8'd45));
    end
    chk(seen, 5'h1F);
    // traffic-light threshold edges
    tl_route = 3'h1; bs_en = 1'b0;
    foreach (deg[i]) if (i > 0) begin
      trig = (i == 6) ? 7'h5A : deg[i][6:0];
      cfg();
      drv(3'h4, deg[i] - 8'd1); chk(outs, 5'h00);
      drv(3'h4, {1'b0, trig}); chk(outs, 5'h10);
      drv(3'h4, 8'd90); chk(outs, 5'h10);
      drv(3'h4, 8'd91); chk(outs, 5'h00);
    end
    trig = 7'h00; cfg();
    drv(3'h0, 8'h00); chk(outs, 5'h00);
    drv(3'h5, 8'h00); chk(outs, 5'h10);
    // randomised static configurations, plain on/off per state
    repeat (40) begin
      tl_route = 3'($urandom); bs_route = 3'($urandom); bs_en = 1'($urandom);
      trig = 7'($urandom_range(0, 100));
      bs_map = 7'($urandom); rs = 3'h0; lw = 3'h0;
      cfg();
      d[10:8] = 3'($urandom_range(0, 7));
      d[7:0] = 8'($urandom_range(0, 120));
      drv(d[10:8], d[7:0]); chk(outs, exp_vec(d[10:8], d[7:0]));
    end
    // angle options of raising and lowering, result holds for the rest of the state
    tl_route = 3'h0; bs_route = 3'h4; bs_en = 1'b1; bs_map = 7'h24;
    for (int o = 1; o < 7; o++) begin
      rs = 3'(o); lw = 3'(o); cfg();
      drv(3'h0, 8'h00); drv(3'h5, 8'h00); chk(outs, 5'h00);
      drv(3'h5, deg[o] - 8'd1); chk(outs, 5'h00);
      drv(3'h5, deg[o]); chk(outs, 5'h02);
      drv(3'h5, 8'h00); chk(outs, 5'h02);
      drv(3'h3, 8'd90); drv(3'h2, 8'd90); chk(outs, 5'h02);
      drv(3'h2, deg[o] + 8'd1); chk(outs, 5'h02);
      drv(3'h2, deg[o]); chk(outs, 5'h00);
      drv(3'h2, 8'd90); chk(outs, 5'h00);
    end
    // register port: clamp, option code 7, status readback, unmapped, frozen by ce
    wr_reg(8'h00, 32'h0000_6403); rd_reg(8'h00, d); chk(d, 32'h0000_5A03);
    wr_reg(8'h08, 32'h0000_7700); rd_reg(8'h08, d); chk(d, 32'h0000_0000);
    drv(3'h6, 8'd77);
    rd_reg(8'h0C, d); chk({d[23:16], 5'h00, d[10:8]}, {8'd77, 8'h06});
    wr_reg(8'h0C, 32'hFFFF_FFFF); rd_reg(8'h10, d); chk(d, 32'h0000_0000);
    @(posedge ref_clk);
    ce <= 1'b0; wr_reg(8'h04, 32'h0000_0051); ce <= 1'b1;
    rd_reg(8'h04, d); chk(d, 32'h0000_0041);
    // reset in mid-run drops every output at once
    tl_route = 3'h5; bs_route = 3'h3; bs_map = 7'h7F; rs = 3'h0; lw = 3'h0; cfg();
    drv(3'h3, 8'd90); chk(outs, exp_vec(3'h3, 8'd90));
    @(posedge ref_clk);
    rst <= 1'b1;
    #5 chk(outs, 5'h00);
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    drv(3'h5, 8'd45); chk(outs, 5'h00);
    complete_run();
  end
endmodule : bsi_indicator_tb_top
